// file: common/crfsu_pkg.sv
// constants for the cpu register, flag and stack unit
package crfsu_pkg;
	localparam int DAT_W = 4;
	localparam int PC_W  = 14;
	localparam int SP_W  = 10;
	localparam int IRQ_N = 11;
	localparam logic [PC_W-1:0] PC_RST = 14'h0000;
	localparam logic [SP_W-1:0] SP_RST = 10'h3FF;
	localparam logic [3:0] SP_TOP = 4'hF;
	localparam logic [SP_W-1:0] SP_STEP = 10'h004;
	// apb byte offsets
	localparam logic [7:0] OFF_ACC = 8'h00;
	localparam logic [7:0] OFF_OPB = 8'h04;
	localparam logic [7:0] OFF_PAGE = 8'h08;
	localparam logic [7:0] OFF_HIX = 8'h0C;
	localparam logic [7:0] OFF_LOX = 8'h10;
	localparam logic [7:0] OFF_AHIX = 8'h14;
	localparam logic [7:0] OFF_ALOX = 8'h18;
	localparam logic [7:0] OFF_CARRY = 8'h1C;
	localparam logic [7:0] OFF_CMD = 8'h20;
	localparam logic [7:0] OFF_PC = 8'h24;
	localparam logic [7:0] OFF_SP = 8'h28;
	localparam logic [7:0] OFF_COND = 8'h2C;
	localparam logic [7:0] OFF_GIE = 8'h30;
	localparam logic [7:0] OFF_MASK = 8'h34;
	localparam logic [7:0] OFF_IF = 8'h38;
	// command field positions
	localparam int CMD_OVF = 4;
	localparam int CMD_RES = 5;
	localparam int CMD_TGT = 16;
	// command codes
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ARITH = 4'h1;
	localparam logic [3:0] OP_TEST = 4'h2;
	localparam logic [3:0] OP_CSET = 4'h3;
	localparam logic [3:0] OP_CCLR = 4'h4;
	localparam logic [3:0] OP_RLC = 4'h5;
	localparam logic [3:0] OP_RRC = 4'h6;
	localparam logic [3:0] OP_BRANCH = 4'h7;
	localparam logic [3:0] OP_CALL = 4'h8;
	localparam logic [3:0] OP_INT = 4'h9;
	localparam logic [3:0] OP_RET = 4'hA;
	localparam logic [3:0] OP_RETI = 4'hB;
	localparam logic [3:0] OP_RSPC = 4'hC;
	localparam logic [3:0] OP_STEP = 4'hD;
	// apb answer phase
	typedef enum logic [0:0] {CRFSU_IDLE, CRFSU_ANS} crfsu_st_t;
endpackage

// file: design/crfsu_top.sv
// cpu register, flag and stack unit behind an apb slave
`timescale 1ns/1ps
module crfsu_top
	import crfsu_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// reset pin, high active, asynchronous to pclk
	input  wire logic              mcu_reset,
	// interrupt request pulses
	input  wire logic [IRQ_N-1:0]  irq_req,
	// interrupt control state
	output logic                   global_interrupt_enable,
	output logic      [IRQ_N-1:0]  interrupt_mask_bit,
	output logic      [IRQ_N-1:0]  irq_flags,
	// addressing outputs
	output logic      [SP_W-1:0]   ram_ind_addr,
	output logic      [DAT_W-1:0]  d_pin_sel
);

	////////////////////////////////////////////////////////////////////
	// state
	logic [DAT_W-1:0] accumulator_r;
	logic [DAT_W-1:0] second_operand_r;
	logic [1:0]       page_index_r;
	logic [DAT_W-1:0] high_index_r;
	logic [DAT_W-1:0] low_index_r;
	logic [DAT_W-1:0] alt_high_index_r;
	logic [DAT_W-1:0] alt_low_index_r;
	logic             carry_flag_r;
	logic             carry_flag_nxt;
	logic             branch_condition_flag_r;
	logic             branch_condition_flag_nxt;
	logic [PC_W-1:0]  program_counter_r;
	logic [PC_W-1:0]  pc_nxt;
	logic [3:0]       level_r;
	logic [3:0]       level_nxt;
	logic [PC_W+1:0]  frame_mem [16];
	logic             rst_s1_r;
	logic             rst_s2_r;
	logic             rst_s3_r;
	logic             rst_lvl_r;
	crfsu_st_t        ans_r;

	////////////////////////////////////////////////////////////////////
	// apb decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	wire setup   = psel & ~penable & (ans_r == CRFSU_IDLE);
	wire access  = psel & penable & pready;
	wire wr      = access & pwrite;
	wire cmd_go  = wr & hit(paddr, OFF_CMD);
	wire [3:0] op = pwdata[3:0];
	wire ovf     = pwdata[CMD_OVF];
	wire res     = pwdata[CMD_RES];
	wire [PC_W-1:0] tgt = pwdata[CMD_TGT +: PC_W];
	wire [PC_W-1:0] pc_inc = program_counter_r + 14'h0001;
	wire [3:0] lvl_dn = level_r - 4'h1;
	wire [PC_W+1:0] top_frame = frame_mem[lvl_dn];

	// stack pointer: upper bits fixed, lower six step by four
	wire [SP_W-1:0] stack_pointer = {SP_TOP, ~level_r, 2'b11};

	wire mapped = hit(paddr, OFF_ACC) | hit(paddr, OFF_OPB) |
		hit(paddr, OFF_PAGE) | hit(paddr, OFF_HIX) |
		hit(paddr, OFF_LOX) | hit(paddr, OFF_AHIX) |
		hit(paddr, OFF_ALOX) | hit(paddr, OFF_CARRY) |
		hit(paddr, OFF_CMD) | hit(paddr, OFF_PC) |
		hit(paddr, OFF_SP) | hit(paddr, OFF_COND) |
		hit(paddr, OFF_GIE) | hit(paddr, OFF_MASK) | hit(paddr, OFF_IF);

	// read mux, sampled in the setup cycle
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (paddr)
			OFF_ACC:   rd_mux[DAT_W-1:0] = accumulator_r;
			OFF_OPB:   rd_mux[DAT_W-1:0] = second_operand_r;
			OFF_PAGE:  rd_mux[1:0] = page_index_r;
			OFF_HIX:   rd_mux[DAT_W-1:0] = high_index_r;
			OFF_LOX:   rd_mux[DAT_W-1:0] = low_index_r;
			OFF_AHIX:  rd_mux[DAT_W-1:0] = alt_high_index_r;
			OFF_ALOX:  rd_mux[DAT_W-1:0] = alt_low_index_r;
			OFF_CARRY: rd_mux[0] = carry_flag_r;
			OFF_PC:    rd_mux[PC_W-1:0] = program_counter_r;
			OFF_SP:    rd_mux[SP_W-1:0] = stack_pointer;
			OFF_COND:  rd_mux[0] = branch_condition_flag_r;
			OFF_GIE:   rd_mux[0] = global_interrupt_enable;
			OFF_MASK:  rd_mux[IRQ_N-1:0] = interrupt_mask_bit;
			OFF_IF:    rd_mux[IRQ_N-1:0] = irq_flags;
			default:   rd_mux = 32'h00000000;
		endcase
	end

	// answer one cycle after setup, i.e. in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ans_r   <= CRFSU_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			case (ans_r)
				CRFSU_IDLE: begin
					if (setup) begin
						ans_r   <= CRFSU_ANS;
						pready  <= 1'b1;
						pslverr <= ~mapped;
						prdata  <= pwrite ? 32'h00000000 : rd_mux;
					end
				end
				CRFSU_ANS: begin
					ans_r   <= CRFSU_IDLE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
					prdata  <= 32'h00000000;
				end
				default: ans_r <= CRFSU_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// reset pin synchroniser, level taken when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_s1_r  <= 1'b0;
			rst_s2_r  <= 1'b0;
			rst_s3_r  <= 1'b0;
			rst_lvl_r <= 1'b0;
		end else begin
			rst_s1_r <= mcu_reset;
			rst_s2_r <= rst_s1_r;
			rst_s3_r <= rst_s2_r;
			if (rst_s2_r == rst_s3_r)
				rst_lvl_r <= rst_s3_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// data and index registers, no reset value
	always_ff @(posedge pclk) begin
		if (wr & hit(paddr, OFF_ACC))
			accumulator_r <= pwdata[DAT_W-1:0];
		else if (cmd_go & (op == OP_RLC))
			accumulator_r <= {accumulator_r[2:0], carry_flag_r};
		else if (cmd_go & (op == OP_RRC))
			accumulator_r <= {carry_flag_r, accumulator_r[3:1]};
		if (wr & hit(paddr, OFF_OPB))
			second_operand_r <= pwdata[DAT_W-1:0];
		if (wr & hit(paddr, OFF_PAGE))
			page_index_r <= pwdata[1:0];
		if (wr & hit(paddr, OFF_HIX))
			high_index_r <= pwdata[DAT_W-1:0];
		if (wr & hit(paddr, OFF_LOX))
			low_index_r <= pwdata[DAT_W-1:0];
		if (wr & hit(paddr, OFF_AHIX))
			alt_high_index_r <= pwdata[DAT_W-1:0];
		if (wr & hit(paddr, OFF_ALOX))
			alt_low_index_r <= pwdata[DAT_W-1:0];
		carry_flag_r <= carry_flag_nxt;
	end

	// carry next value
	always_comb begin
		carry_flag_nxt = carry_flag_r;
		if (wr & hit(paddr, OFF_CARRY))
			carry_flag_nxt = pwdata[0];
		else if (cmd_go) begin
			case (op)
				OP_ARITH: carry_flag_nxt = ovf;
				OP_CSET:  carry_flag_nxt = 1'b1;
				OP_CCLR:  carry_flag_nxt = 1'b0;
				OP_RLC:   carry_flag_nxt = accumulator_r[3];
				OP_RRC:   carry_flag_nxt = accumulator_r[0];
				OP_RETI:  carry_flag_nxt = top_frame[1];
				default:  carry_flag_nxt = carry_flag_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// status, program counter and stack level next values
	always_comb begin
		branch_condition_flag_nxt = branch_condition_flag_r;
		pc_nxt                    = program_counter_r;
		level_nxt                 = level_r;
		if (cmd_go) begin
			case (op)
				OP_ARITH: branch_condition_flag_nxt = res;
				OP_TEST:  branch_condition_flag_nxt = res;
				OP_BRANCH: begin
					pc_nxt = branch_condition_flag_r ? tgt : pc_inc;
					branch_condition_flag_nxt = 1'b1;
				end
				OP_CALL: begin
					if (branch_condition_flag_r) begin
						pc_nxt    = tgt;
						level_nxt = level_r + 4'h1;
					end else
						pc_nxt = pc_inc;
					branch_condition_flag_nxt = 1'b1;
				end
				OP_INT: begin
					pc_nxt    = tgt;
					level_nxt = level_r + 4'h1;
				end
				OP_RET: begin
					pc_nxt    = top_frame[PC_W+1:2];
					level_nxt = lvl_dn;
				end
				OP_RETI: begin
					pc_nxt                    = top_frame[PC_W+1:2];
					branch_condition_flag_nxt = top_frame[0];
					level_nxt                 = lvl_dn;
				end
				OP_RSPC: level_nxt = 4'h0;
				OP_STEP: pc_nxt = pc_inc;
				default: branch_condition_flag_nxt = branch_condition_flag_r;
			endcase
		end
	end

	wire push_call = cmd_go & (op == OP_CALL) & branch_condition_flag_r;
	wire push_int  = cmd_go & (op == OP_INT);

	// stack frames: return address, carry, status
	always_ff @(posedge pclk) begin
		if (push_call)
			frame_mem[level_r] <= {pc_inc, carry_flag_r, branch_condition_flag_r};
		else if (push_int)
			frame_mem[level_r] <= {program_counter_r, carry_flag_r,
				branch_condition_flag_r};
	end

	// cpu state with reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_condition_flag_r <= 1'b1;
			program_counter_r       <= PC_RST;
			level_r                 <= 4'h0;
		end else if (rst_lvl_r) begin
			branch_condition_flag_r <= 1'b1;
			program_counter_r       <= PC_RST;
			level_r                 <= 4'h0;
		end else begin
			branch_condition_flag_r <= branch_condition_flag_nxt;
			program_counter_r       <= pc_nxt;
			level_r                 <= level_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt control bits; request set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_interrupt_enable <= 1'b0;
			interrupt_mask_bit      <= '1;
			irq_flags               <= '0;
		end else if (rst_lvl_r) begin
			global_interrupt_enable <= 1'b0;
			interrupt_mask_bit      <= '1;
			irq_flags               <= '0;
		end else begin
			if (wr & hit(paddr, OFF_GIE))
				global_interrupt_enable <= pwdata[0];
			if (wr & hit(paddr, OFF_MASK))
				interrupt_mask_bit <= pwdata[IRQ_N-1:0];
			irq_flags <= (irq_flags & ~({IRQ_N{wr & hit(paddr, OFF_IF)}} &
				pwdata[IRQ_N-1:0])) | irq_req;
		end
	end

	// addressing outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_ind_addr <= '0;
			d_pin_sel    <= '0;
		end else begin
			ram_ind_addr <= {page_index_r, high_index_r, low_index_r};
			d_pin_sel    <= low_index_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sp_top_ones: assert property (stack_pointer[9:6] == SP_TOP)
		else $error("stack pointer upper bits not ones");

	// flags and level of the last interrupt entry, kept for the restore check
	logic             chk_int_carry_r;
	logic             chk_int_cond_r;
	logic [3:0]       chk_int_lvl_r;
	always_ff @(posedge pclk) begin
		if (push_int) begin
			chk_int_carry_r <= carry_flag_r;
			chk_int_cond_r  <= branch_condition_flag_r;
			chk_int_lvl_r   <= level_r;
		end
	end

	a_cond_after_branch: assert property (
		cmd_go && (op == OP_BRANCH || op == OP_CALL) && !rst_lvl_r
		|=> branch_condition_flag_r)
		else $error("status not one after branch");

	a_sp_call_dec: assert property (
		push_call && !rst_lvl_r
		|=> stack_pointer == $past(stack_pointer) - SP_STEP)
		else $error("stack pointer not lowered by four");

	a_sp_int_dec: assert property (
		push_int && !rst_lvl_r
		|=> stack_pointer == $past(stack_pointer) - SP_STEP)
		else $error("stack pointer not lowered on interrupt entry");

	a_call_skipped: assert property (
		cmd_go && op == OP_CALL && !branch_condition_flag_r && !rst_lvl_r
		|=> $stable(stack_pointer) &&
		program_counter_r == $past(program_counter_r) + 14'h0001)
		else $error("call taken with status clear");

	a_ret_keeps_flags: assert property (
		cmd_go && op == OP_RET && !rst_lvl_r
		|=> $stable(branch_condition_flag_r) &&
		stack_pointer == $past(stack_pointer) + SP_STEP)
		else $error("return changed status or stack pointer");

	a_int_reti_flags: assert property (
		cmd_go && op == OP_RETI && !rst_lvl_r && lvl_dn == chk_int_lvl_r
		|=> carry_flag_r == chk_int_carry_r &&
		branch_condition_flag_r == chk_int_cond_r)
		else $error("interrupt return did not restore flags");

	a_rst_pin_vals: assert property (
		rst_lvl_r |=> program_counter_r == PC_RST &&
		stack_pointer == SP_RST && branch_condition_flag_r &&
		!global_interrupt_enable && interrupt_mask_bit == '1)
		else $error("reset values wrong");

	a_sp_reload: assert property (
		cmd_go && op == OP_RSPC |=> stack_pointer == SP_RST)
		else $error("stack pointer not reloaded");

	a_carry_arith: assert property (
		cmd_go && op == OP_ARITH && !rst_lvl_r
		|=> carry_flag_r == $past(pwdata[CMD_OVF]))
		else $error("carry not overflow");

	a_cond_held: assert property (
		!cmd_go && !rst_lvl_r |=> $stable(branch_condition_flag_r))
		else $error("status changed without cause");

	a_pin_sel: assert property (
		wr && hit(paddr, OFF_LOX) |-> ##2 d_pin_sel == $past(pwdata[3:0], 2))
		else $error("d pin select wrong");

	// bus answer: ready lasts one cycle, error only with ready
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");

endmodule

// file: test/tb_crfsu_top.sv
// self-checking apb bench for the cpu register, flag and stack unit
`timescale 1ns/1ps
module tb_crfsu_top;
	import crfsu_pkg::*;
	// clock and resets
	logic              pclk;
	logic              presetn;
	logic              mcu_reset;
	// apb master side
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	// interrupt and addressing pins
	logic [IRQ_N-1:0]  irq_req;
	logic              global_interrupt_enable;
	logic [IRQ_N-1:0]  interrupt_mask_bit;
	logic [IRQ_N-1:0]  irq_flags;
	logic [SP_W-1:0]   ram_ind_addr;
	logic [DAT_W-1:0]  d_pin_sel;
	// bookkeeping
	int                bad_count;
	int                checks;
	logic [31:0]       rd_val;
	logic              rd_err;
	localparam logic [7:0] DOFF [7] = '{OFF_ACC, OFF_OPB, OFF_PAGE, OFF_HIX, OFF_LOX, OFF_AHIX,
		OFF_ALOX};
	localparam logic [31:0] DMSK [7] = '{32'hF, 32'hF, 32'h3, 32'hF, 32'hF, 32'hF, 32'hF};

	////////////////////////////////////////////////////////////////////////////////
	// design under test
	crfsu_top crfsu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mcu_reset(mcu_reset), .irq_req(irq_req),
		.global_interrupt_enable(global_interrupt_enable),
		.interrupt_mask_bit(interrupt_mask_bit), .irq_flags(irq_flags),
		.ram_ind_addr(ram_ind_addr), .d_pin_sel(d_pin_sel));

	// 125 mhz clock
	always #4 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// compare one value
	task automatic chk(input string what, input logic [31:0] exp_v, input logic [31:0] got_v);
		checks++;
		if (got_v !== exp_v) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp_v, got_v);
		end
	endtask

	// one apb transfer, entered and left just after a rising edge
	task automatic xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] dat);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= addr;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			$display("MISMATCH pready expected 1 seen timeout");
			finish_test();
		end else begin
			rd_val = prdata;
			rd_err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	// register write
	task automatic wr(input logic [7:0] addr, input logic [31:0] dat);
		xfer(1'b1, addr, dat);
	endtask

	// register read compared with an expected word, no error allowed
	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp_v);
		xfer(1'b0, addr, 32'h0000_0000);
		chk(what, exp_v, rd_val);
		chk("read_err", 32'h0, 32'(rd_err));
	endtask

	// issue one command through the command register
	task automatic op(input logic [3:0] code, input logic ovf, input logic res,
		input logic [PC_W-1:0] tgt);
		logic [31:0] word;
		word = 32'h0;
		word[3:0] = code;
		word[CMD_OVF] = ovf;
		word[CMD_RES] = res;
		word[CMD_TGT +: PC_W] = tgt;
		wr(OFF_CMD, word);
	endtask

	// program counter, stack pointer and condition flag in one go
	task automatic core_chk(input logic [PC_W-1:0] cnt, input logic [SP_W-1:0] ptr, input logic cf);
		rd_chk("prog_cnt", OFF_PC, 32'(cnt));
		rd_chk("stk_ptr", OFF_SP, 32'(ptr));
		rd_chk("cond_flag", OFF_COND, 32'(cf));
	endtask

	// state that both reset inputs must establish
	task automatic reset_chk();
		core_chk(PC_RST, SP_RST, 1'b1);
		rd_chk("irq_enable", OFF_GIE, 32'h0);
		rd_chk("irq_mask", OFF_MASK, 32'h0000_07FF);
		rd_chk("irq_flag_reg", OFF_IF, 32'h0);
		chk("mask_pins", 32'h0000_07FF, 32'(interrupt_mask_bit));
		chk("enable_pin", 32'h0, 32'(global_interrupt_enable));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		mcu_reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_req = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset pin kept high at power-on while the oscillator settles
		repeat (16) @(posedge pclk);
		mcu_reset <= 1'b0;
		repeat (6) @(posedge pclk);
		reset_chk();
		for (int i = 0; i < 7; i++) begin
			wr(DOFF[i], 32'hFFFF_FFF0 | 32'(i + 9));
		end
		for (int i = 0; i < 7; i++) begin
			rd_chk("data_reg", DOFF[i], 32'(i + 9) & DMSK[i]);
		end
		chk("ram_addr", 32'h0000_03CD, 32'(ram_ind_addr));
		chk("d_pin", 32'h0000_000D, 32'(d_pin_sel));
		// unmapped read and ignored writes to read-only places
		xfer(1'b0, 8'h3C, 32'h0);
		chk("unmapped_err", 32'h1, 32'(rd_err));
		chk("unmapped_data", 32'h0, rd_val);
		wr(OFF_PC, 32'h0000_1111);
		wr(OFF_SP, 32'h0000_0000);
		// carry from arithmetic, set, clear and rotates
		op(OP_ARITH, 1'b1, 1'b0, '0);
		rd_chk("carry", OFF_CARRY, 32'h1);
		rd_chk("cond_flag", OFF_COND, 32'h0);
		op(OP_ARITH, 1'b0, 1'b1, '0);
		rd_chk("carry", OFF_CARRY, 32'h0);
		op(OP_CSET, 1'b0, 1'b0, '0);
		rd_chk("carry", OFF_CARRY, 32'h1);
		op(OP_CCLR, 1'b0, 1'b0, '0);
		rd_chk("carry", OFF_CARRY, 32'h0);
		wr(OFF_ACC, 32'h9);
		op(OP_RLC, 1'b0, 1'b0, '0);
		rd_chk("acc", OFF_ACC, 32'h2);
		rd_chk("carry", OFF_CARRY, 32'h1);
		op(OP_RRC, 1'b0, 1'b0, '0);
		rd_chk("acc", OFF_ACC, 32'h9);
		rd_chk("carry", OFF_CARRY, 32'h0);
		// condition flag held, branches taken and not taken
		op(OP_TEST, 1'b0, 1'b0, '0);
		op(OP_NOP, 1'b0, 1'b0, '0);
		rd_chk("cond_flag", OFF_COND, 32'h0);
		op(OP_BRANCH, 1'b0, 1'b0, 14'h2AAA);
		core_chk(14'h0001, SP_RST, 1'b1);
		op(OP_BRANCH, 1'b0, 1'b0, 14'h1234);
		core_chk(14'h1234, SP_RST, 1'b1);
		// call, interrupt entry, returns
		op(OP_CSET, 1'b0, 1'b0, '0);
		op(OP_CALL, 1'b0, 1'b0, 14'h0100);
		core_chk(14'h0100, 10'h3FB, 1'b1);
		op(OP_TEST, 1'b0, 1'b0, '0);
		op(OP_INT, 1'b0, 1'b0, 14'h0200);
		core_chk(14'h0200, 10'h3F7, 1'b0);
		op(OP_ARITH, 1'b0, 1'b1, '0);
		op(OP_RETI, 1'b0, 1'b0, '0);
		core_chk(14'h0100, 10'h3FB, 1'b0);
		rd_chk("carry", OFF_CARRY, 32'h1);
		op(OP_ARITH, 1'b0, 1'b1, '0);
		op(OP_RET, 1'b0, 1'b0, '0);
		core_chk(14'h1235, SP_RST, 1'b1);
		rd_chk("carry", OFF_CARRY, 32'h0);
		op(OP_TEST, 1'b0, 1'b0, '0);
		op(OP_CALL, 1'b0, 1'b0, 14'h0300);
		core_chk(14'h1236, SP_RST, 1'b1);
		op(OP_CALL, 1'b0, 1'b0, 14'h0300);
		op(OP_RSPC, 1'b0, 1'b0, '0);
		op(OP_STEP, 1'b0, 1'b0, '0);
		core_chk(14'h0301, SP_RST, 1'b1);
		// interrupt control registers and request flags
		wr(OFF_GIE, 32'h1);
		wr(OFF_MASK, 32'h0000_0055);
		chk("enable_pin", 32'h1, 32'(global_interrupt_enable));
		chk("mask_pins", 32'h0000_0055, 32'(interrupt_mask_bit));
		irq_req <= 11'h008;
		@(posedge pclk);
		irq_req <= '0;
		@(posedge pclk);
		rd_chk("irq_flag_reg", OFF_IF, 32'h8);
		wr(OFF_IF, 32'h8);
		rd_chk("irq_flag_reg", OFF_IF, 32'h0);
		irq_req <= 11'h400;
		@(posedge pclk);
		irq_req <= '0;
		@(posedge pclk);
		chk("flag_pins", 32'h400, 32'(irq_flags));
		// reset pin held well beyond two instruction cycles
		mcu_reset <= 1'b1;
		repeat (8) @(posedge pclk);
		mcu_reset <= 1'b0;
		repeat (6) @(posedge pclk);
		reset_chk();
		rd_chk("acc", OFF_ACC, 32'h9);
		finish_test();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		$display("MISMATCH run expected done seen timeout");
		finish_test();
	end
endmodule
